// ---- common/twi_defs.svh ----
/*
 Timing counts, bus codes and addresses for the two-wire register port.
 Assumes the includer runs on mclk at 25 MHz.
*/
`ifndef TWI_DEFS_SVH
`define TWI_DEFS_SVH
`define MCLK_HZ 25000000
`define ADDR_SEL1 7'h48
`define ADDR_SEL0 7'h40
`define GCALL_BYTE 8'h00
`define MCODE_PFX 5'h01
`define FILT_LS 4
`define FILT_HS 1
`define LS_RATE_HZ 1000000
`define HS_RATE_HZ 3400000
`define LS_HALF ((`MCLK_HZ / `LS_RATE_HZ) / 2)
`define HS_HALF 4
`endif

// ---- common/twi_pkg.sv ----
/*
 Types shared by both ends of the two-wire register port.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package twi_pkg;
   typedef enum logic [2:0] {
      S_IDLE, S_ADDR, S_PTR, S_WDATA, S_RDATA, S_ACKOUT, S_ACKIN, S_IGNORE
   } slv_state_t;
   typedef enum logic [3:0] {
      M_IDLE, M_START, M_BIT, M_ACK, M_STOP, M_RSTART, M_DONE
   } mst_state_t;
endpackage

// ---- common/twi_if.sv ----
/*
 Open-drain two-wire bus joining the register-port slave and a master.
 Each party gives an output value and an active-low enable per line;
 the wired-AND level is resolved here with pull-ups.
*/
interface twi_if;
   logic scl_o_m;
   logic scl_oe_n_m;
   logic sda_o_m;
   logic sda_oe_n_m;
   logic scl_o_s;
   logic scl_oe_n_s;
   logic sda_o_s;
   logic sda_oe_n_s;
   wire scl;
   wire sda;
   assign scl = (!scl_oe_n_m && !scl_o_m) || (!scl_oe_n_s && !scl_o_s) ? 1'b0 : 1'b1;
   assign sda = (!sda_oe_n_m && !sda_o_m) || (!sda_oe_n_s && !sda_o_s) ? 1'b0 : 1'b1;
   modport master (output scl_o_m, output scl_oe_n_m, output sda_o_m, output sda_oe_n_m,
      input scl, input sda);
   modport slave (output scl_o_s, output scl_oe_n_s, output sda_o_s, output sda_oe_n_s,
      input scl, input sda);
endinterface

// ---- design/twi_slave.sv ----
/*
 Slave end of the two-wire register port: address match, pointer,
 sequential write and read, master-code speed switch.
 Assumes scl/sda are synchronous to mclk and the register store sits outside.
*/
// Function
// (R1) Never drive the clock line low
// (R2) Do not acknowledge general call address
// (R3) Low speeds need no entry sequence
// (R4) Low-speed filter after reset and stop
// (R5) High-speed filters while high speed engaged
// (R6) Start, address, write bit, acknowledge match
// (R7) Acknowledge and load register pointer
// (R8) Commit write byte at sda rise
// (R9) Acknowledge and commit each further byte
// (R10) Accept ack or nack on last
// (R11) Repeated start, read address, send byte
// (R12) Keep sending while master acknowledges
// (R13) Master nacks last byte, slave releases
// (R14) Stop keeps the register pointer
// (R15) Repeated start keeps filter selection
// (R16) Snapshot timekeeping on read header
// (R17) Master code nacked, selects high speed
// (R18) High speed lasts until stop
// (R19) Pointer increments after each data byte
// (R20) Match 0x48 or 0x40 by select
// (R21) Ignore clock until next start
// (R22) Acknowledge every pointer value
// (R23) Start, stop from line transitions only
`include "twi_defs.svh"
module twi_slave #(
   parameter int FILT_LS = `FILT_LS,
   parameter int FILT_HS = `FILT_HS
) (
   input wire logic mclk,
   input wire logic nrst,
   twi_if.slave bus,
   input wire logic addr_sel,
   input wire logic [7:0] rd_data,
   output logic [7:0] reg_ptr,
   output logic [7:0] wr_data,
   output logic wr_stb,
   output logic snap_stb,
   output logic hs_mode
);
   // ----------------------------------------
   // Input filters
   // ----------------------------------------
   logic [3:0] scl_cnt_q, sda_cnt_q;
   logic scl_f_q, sda_f_q, scl_p_q, sda_p_q;
   logic hs_q;
   // (R3) Low-speed filter needs no entry
   wire [3:0] filt_len = hs_q ? 4'(FILT_HS) : 4'(FILT_LS);
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         scl_cnt_q <= 4'h0;
         sda_cnt_q <= 4'h0;
         scl_f_q <= 1'b1;
         sda_f_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         // (R5) Filter length by mode
         scl_cnt_q <= (bus.scl == scl_f_q) ? 4'h0 : scl_cnt_q + 4'h1;
         sda_cnt_q <= (bus.sda == sda_f_q) ? 4'h0 : sda_cnt_q + 4'h1;
         if (bus.scl != scl_f_q && scl_cnt_q + 4'h1 >= filt_len) scl_f_q <= bus.scl;
         if (bus.sda != sda_f_q && sda_cnt_q + 4'h1 >= filt_len) sda_f_q <= bus.sda;
         scl_p_q <= scl_f_q;
         sda_p_q <= sda_f_q;
      end
   end
   // (R23) Conditions from line edges
   wire start_c = scl_f_q && scl_p_q && sda_p_q && !sda_f_q;
   wire stop_c = scl_f_q && scl_p_q && !sda_p_q && sda_f_q;
   wire scl_rise = scl_f_q && !scl_p_q;
   wire scl_fall = !scl_f_q && scl_p_q;
   wire sda_rise = sda_f_q && !sda_p_q;
   // ----------------------------------------
   // Protocol engine
   // ----------------------------------------
   twi_pkg::slv_state_t st_q, ret_q;
   logic [7:0] sh_q, ptr_q, wd_q;
   logic [3:0] bit_q;
   logic rd_q, ack_q, ptr_done_q, pend_q, sda_drv_q, wr_q, snap_q;
   wire [7:0] rx_byte = {sh_q[6:0], sda_f_q};
   // (R20) Address select match
   wire [6:0] my_addr = addr_sel ? `ADDR_SEL1 : `ADDR_SEL0;
   wire addr_hit = sh_q[7:1] == my_addr;
   // (R17) Master code pattern
   wire mcode = sh_q[7:3] == `MCODE_PFX;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_q <= twi_pkg::S_IDLE;
         ret_q <= twi_pkg::S_IDLE;
         sh_q <= 8'h00;
         ptr_q <= 8'h00;
         wd_q <= 8'h00;
         bit_q <= 4'h0;
         rd_q <= 1'b0;
         ack_q <= 1'b0;
         ptr_done_q <= 1'b0;
         pend_q <= 1'b0;
         sda_drv_q <= 1'b0;
         wr_q <= 1'b0;
         snap_q <= 1'b0;
         hs_q <= 1'b0;
      end else begin
         wr_q <= 1'b0;
         snap_q <= 1'b0;
         // (R8) Commit on sda rise
         if (pend_q && (sda_rise || stop_c)) begin
            wr_q <= 1'b1;
            pend_q <= 1'b0;
         end
         if (stop_c) begin
            // (R4) Stop reverts filters
            hs_q <= 1'b0;
            // (R14) Pointer kept on stop
            st_q <= twi_pkg::S_IDLE;
            sda_drv_q <= 1'b0;
         end else if (start_c) begin
            // (R15) Filters kept on start
            st_q <= twi_pkg::S_ADDR;
            bit_q <= 4'h0;
            sda_drv_q <= 1'b0;
         end else begin
            case (st_q)
               // (R21) Clock ignored here
               twi_pkg::S_IDLE, twi_pkg::S_IGNORE: begin
               end
               twi_pkg::S_ADDR, twi_pkg::S_PTR, twi_pkg::S_WDATA: begin
                  if (scl_rise) begin
                     sh_q <= rx_byte;
                     bit_q <= bit_q + 4'h1;
                  end
                  if (scl_fall && bit_q == 4'h8) begin
                     bit_q <= 4'h0;
                     ack_q <= 1'b1;
                     ret_q <= st_q;
                     st_q <= twi_pkg::S_ACKOUT;
                     if (st_q == twi_pkg::S_ADDR) begin
                        // (R2) General call refused
                        if (sh_q == `GCALL_BYTE) begin
                           ack_q <= 1'b0;
                           st_q <= twi_pkg::S_IGNORE;
                        end else if (mcode) begin
                           // (R17) Nack, engage high speed
                           hs_q <= 1'b1;
                           st_q <= twi_pkg::S_IGNORE;
                        end else if (!addr_hit) begin
                           st_q <= twi_pkg::S_IGNORE;
                        end else begin
                           // (R6) Ack matching header
                           rd_q <= sh_q[0];
                           sda_drv_q <= 1'b1;
                           // (R16) Snapshot on read header
                           snap_q <= sh_q[0];
                        end
                     end else begin
                        // (R22) Every pointer acked
                        sda_drv_q <= 1'b1;
                        if (st_q == twi_pkg::S_PTR) begin
                           // (R7) Load pointer
                           ptr_q <= sh_q;
                        end else begin
                           // (R9) Each byte acked
                           wd_q <= sh_q;
                           pend_q <= 1'b1;
                        end
                     end
                  end
               end
               twi_pkg::S_ACKOUT: begin
                  if (scl_fall) begin
                     sda_drv_q <= 1'b0;
                     if (ret_q == twi_pkg::S_ADDR && rd_q) begin
                        // (R11) First read bit out
                        st_q <= twi_pkg::S_RDATA;
                        sda_drv_q <= !rd_data[7];
                        sh_q <= {rd_data[6:0], 1'b0};
                        bit_q <= 4'h1;
                     end else if (ret_q == twi_pkg::S_WDATA) begin
                        // (R19) Step after write byte
                        ptr_q <= ptr_q + 8'h01;
                        st_q <= twi_pkg::S_WDATA;
                     end else begin
                        st_q <= ret_q == twi_pkg::S_ADDR ? twi_pkg::S_PTR : twi_pkg::S_WDATA;
                     end
                  end
               end
               twi_pkg::S_RDATA: begin
                  if (scl_fall) begin
                     if (bit_q == 4'h8) begin
                        sda_drv_q <= 1'b0;
                        st_q <= twi_pkg::S_ACKIN;
                     end else begin
                        sda_drv_q <= !sh_q[7];
                        sh_q <= {sh_q[6:0], 1'b0};
                        bit_q <= bit_q + 4'h1;
                     end
                  end
               end
               twi_pkg::S_ACKIN: begin
                  if (scl_rise) ack_q <= !sda_f_q;
                  if (scl_fall) begin
                     // (R19) Step after read byte
                     ptr_q <= ptr_q + 8'h01;
                     if (ack_q) begin
                        // (R12) Next byte on ack
                        st_q <= twi_pkg::S_RDATA;
                        sda_drv_q <= !rd_data[7];
                        sh_q <= {rd_data[6:0], 1'b0};
                        bit_q <= 4'h1;
                     end else begin
                        // (R13) Release after nack
                        st_q <= twi_pkg::S_IGNORE;
                     end
                  end
               end
               default: st_q <= twi_pkg::S_IDLE;
            endcase
         end
      end
   end
   // (R10) Master ack slot on writes not sampled
   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign bus.sda_o_s = 1'b0;
   assign bus.sda_oe_n_s = !sda_drv_q;
   // (R1) Clock never driven
   assign bus.scl_o_s = 1'b1;
   assign bus.scl_oe_n_s = 1'b1;
   assign reg_ptr = ptr_q;
   assign wr_data = wd_q;
   assign wr_stb = wr_q;
   assign snap_stb = snap_q;
   // (R18) Mode until stop
   assign hs_mode = hs_q;
endmodule // twi_slave

// ---- design/twi_master.sv ----
/*
 Master end: issues write, read or master-code transfers on request.
 Assumes a single user drives go with a stable command until done.
*/
`include "twi_defs.svh"
module twi_master #(
   parameter int LS_HALF = `LS_HALF,
   parameter int HS_HALF = `HS_HALF
) (
   input wire logic mclk,
   input wire logic nrst,
   twi_if.master bus,
   input wire logic go,
   input wire logic hs_req,
   input wire logic rd,
   input wire logic [6:0] dev_addr,
   input wire logic [7:0] ptr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   output logic nack_err,
   output logic busy,
   output logic done
);
   twi_pkg::mst_state_t st_q;
   logic [7:0] tim_q, sh_q, rx_q;
   logic [3:0] bit_q;
   logic [2:0] ph_q;
   logic scl_q, sda_q, hs_q, err_q, done_q, busy_q;
   // (R3) Half period by speed range
   wire [7:0] half = hs_q ? 8'(HS_HALF) : 8'(LS_HALF);
   wire tick = tim_q == 8'h00;
   // Byte sequence per phase
   function automatic logic [7:0] seq_byte(input logic [2:0] p);
      case (p)
         // (R17) Master code first
         3'h0: seq_byte = hs_req ? {`MCODE_PFX, 3'h0} : {dev_addr, 1'b0};
         3'h1: seq_byte = {dev_addr, 1'b0};
         3'h2: seq_byte = ptr;
         3'h3: seq_byte = rd ? {dev_addr, 1'b1} : wdata;
         default: seq_byte = 8'hff;
      endcase
   endfunction
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_q <= twi_pkg::M_IDLE;
         tim_q <= 8'h00;
         sh_q <= 8'h00;
         rx_q <= 8'h00;
         bit_q <= 4'h0;
         ph_q <= 3'h0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         hs_q <= 1'b0;
         err_q <= 1'b0;
         done_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         tim_q <= tick ? half - 8'h01 : tim_q - 8'h01;
         case (st_q)
            twi_pkg::M_IDLE: if (go) begin
               busy_q <= 1'b1;
               err_q <= 1'b0;
               ph_q <= hs_req ? 3'h0 : 3'h1;
               st_q <= twi_pkg::M_START;
            end
            // (R6) Start then header
            twi_pkg::M_START, twi_pkg::M_RSTART: if (tick) begin
               if (!scl_q) scl_q <= 1'b1;
               else if (sda_q) sda_q <= 1'b0;
               else begin
                  scl_q <= 1'b0;
                  sh_q <= seq_byte(ph_q);
                  bit_q <= 4'h0;
                  st_q <= twi_pkg::M_BIT;
               end
            end
            twi_pkg::M_BIT: if (tick) begin
               if (!scl_q) begin
                  // (R13) Release ack slot, nack
                  sda_q <= bit_q == 4'h8 ? 1'b1 : sh_q[7];
                  scl_q <= 1'b1;
               end else begin
                  rx_q <= {rx_q[6:0], bus.sda};
                  scl_q <= 1'b0;
                  sh_q <= {sh_q[6:0], 1'b1};
                  bit_q <= bit_q + 4'h1;
                  if (bit_q == 4'h8) st_q <= twi_pkg::M_ACK;
               end
            end
            twi_pkg::M_ACK: begin
               if (ph_q != 3'h4 && ph_q != 3'h0 && rx_q[0]) err_q <= 1'b1;
               if (ph_q == 3'h0) begin
                  hs_q <= 1'b1;
                  ph_q <= 3'h1;
                  st_q <= twi_pkg::M_RSTART;
               end else if (ph_q == 3'h1) begin
                  ph_q <= 3'h2;
                  sh_q <= ptr;
                  bit_q <= 4'h0;
                  st_q <= twi_pkg::M_BIT;
               // (R11) Repeated start for read
               end else if (ph_q == 3'h2 && rd) begin
                  ph_q <= 3'h3;
                  sda_q <= 1'b1;
                  st_q <= twi_pkg::M_RSTART;
               end else if (ph_q == 3'h3 && rd) begin
                  ph_q <= 3'h4;
                  sh_q <= 8'hff;
                  bit_q <= 4'h0;
                  st_q <= twi_pkg::M_BIT;
               end else if (ph_q == 3'h2) begin
                  ph_q <= 3'h3;
                  sh_q <= wdata;
                  bit_q <= 4'h0;
                  st_q <= twi_pkg::M_BIT;
               end else begin
                  st_q <= twi_pkg::M_STOP;
                  sda_q <= 1'b0;
               end
            end
            twi_pkg::M_STOP: if (tick) begin
               if (!scl_q) scl_q <= 1'b1;
               else begin
                  sda_q <= 1'b1;
                  hs_q <= 1'b0;
                  st_q <= twi_pkg::M_DONE;
               end
            end
            twi_pkg::M_DONE: begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
               st_q <= twi_pkg::M_IDLE;
            end
            default: st_q <= twi_pkg::M_IDLE;
         endcase
      end
   end
   logic [7:0] rd_q;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) rd_q <= 8'h00;
      else if (st_q == twi_pkg::M_BIT && tick && scl_q && bit_q == 4'h7 && ph_q == 3'h4) begin
         rd_q <= {rx_q[6:0], bus.sda};
      end
   end
   assign rdata = rd_q;
   assign bus.scl_o_m = 1'b0;
   assign bus.scl_oe_n_m = scl_q;
   assign bus.sda_o_m = 1'b0;
   assign bus.sda_oe_n_m = sda_q;
   assign nack_err = err_q;
   assign busy = busy_q;
   assign done = done_q;
endmodule // twi_master

// ---- sim/twi_bus_monitor.sv ----
/*
 Checker for the open-drain bus between the master and slave ends.
 Assumes the bench wires it beside the bus interface with mclk and nrst.
*/
module twi_bus_monitor (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic scl_oe_n_s,
   input wire logic sda_oe_n_s,
   input wire logic scl,
   input wire logic sda
);
   // ----------------
   // Bus tracking
   // ----------------
   logic scl_p_q, sda_p_q, acked_q, quiet_q;
   logic [3:0] bit_q;
   logic [1:0] nb_q;
   logic [7:0] sh_q, hdr_q;
   wire scl_rise = scl && !scl_p_q;
   wire start_ev = scl && scl_p_q && !sda && sda_p_q;
   wire stop_ev = scl && scl_p_q && sda && !sda_p_q;
   wire ack_slot = scl_rise && (bit_q == 4'h8);
   wire first = (nb_q == 2'h0);
   wire wr_hdr = acked_q && !hdr_q[0];
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         acked_q <= 1'b0;
         quiet_q <= 1'b1;
         bit_q <= 4'h0;
         nb_q <= 2'h0;
         sh_q <= 8'h00;
         hdr_q <= 8'h00;
      end else begin
         scl_p_q <= scl;
         sda_p_q <= sda;
         if (start_ev) begin
            bit_q <= 4'h0;
            nb_q <= 2'h0;
            quiet_q <= 1'b0;
         end else if (stop_ev) begin
            quiet_q <= 1'b1;
         end else if (ack_slot) begin
            bit_q <= 4'h0;
            nb_q <= (nb_q == 2'h3) ? nb_q : nb_q + 2'h1;
            if (first) begin
               hdr_q <= sh_q;
               acked_q <= !sda;
               quiet_q <= sda;
            end
         end else if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda};
            bit_q <= bit_q + 4'h1;
         end
      end
   end
   // ----------------
   // Assertions
   // ----------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   a_no_clk_stretch: assert property (scl_oe_n_s)
      else $error("slave pulled the clock line");
   a_gcall_nack: assert property (ack_slot && first && sh_q == 8'h00 |-> sda)
      else $error("general call acknowledged");
   a_mcode_nack: assert property (ack_slot && first && sh_q[7:3] == 5'h01 |-> sda)
      else $error("master code acknowledged");
   a_foreign_nack: assert property (ack_slot && first && sh_q[7:1] != 7'h48
      && sh_q[7:1] != 7'h40 |-> sda)
      else $error("foreign address acknowledged");
   a_ptr_ack: assert property (ack_slot && nb_q == 2'h1 && wr_hdr |-> !sda)
      else $error("pointer byte not acknowledged");
   a_data_ack: assert property (ack_slot && nb_q == 2'h2 && wr_hdr |-> !sda)
      else $error("data byte not acknowledged");
   a_rd_release: assert property (ack_slot && !first && acked_q && hdr_q[0]
      |-> sda_oe_n_s)
      else $error("slave held data during master ack");
   a_quiet_slave: assert property (quiet_q |-> sda_oe_n_s)
      else $error("slave drove data while deselected");
   a_sda_chg_low: assert property ($changed(sda_oe_n_s) |-> !scl)
      else $error("slave changed data with clock high");
   a_ack_hold: assert property (ack_slot && !sda_oe_n_s |=> !sda_oe_n_s [*2])
      else $error("slave ack dropped in clock high");
endmodule // twi_bus_monitor

// ---- sim/i2c_slave_register_port_tb.sv ----
/*
 Self-checking bench: master and slave ends joined over one bus.
 Assumes a 25 MHz mclk and the design's default timing parameters.
*/
module i2c_slave_register_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic go = 1'b0;
   logic hs_req = 1'b0;
   logic rd = 1'b0;
   logic addr_sel = 1'b0;
   logic [6:0] dev_addr = 7'h00;
   logic [7:0] ptr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rd_data, reg_ptr, wr_data, rdata;
   logic wr_stb, snap_stb, hs_mode, nack_err, busy, done;
   logic hs_seen = 1'b0;
   logic hs_drop = 1'b0;
   logic [7:0] mem [256];
   logic [7:0] exp_mem [256];
   logic [6:0] bad [4] = '{7'h00, 7'h40, 7'h48, 7'h7f};
   int n_errors = 0;
   int num_checks = 0;
   int n_snap = 0;
   int cyc = 0;
   twi_if bus_if ();
   twi_slave twi_slave_i (.mclk(mclk), .nrst(nrst), .bus(bus_if), .addr_sel(addr_sel),
      .rd_data(rd_data), .reg_ptr(reg_ptr), .wr_data(wr_data), .wr_stb(wr_stb),
      .snap_stb(snap_stb), .hs_mode(hs_mode));
   twi_master twi_master_i (.mclk(mclk), .nrst(nrst), .bus(bus_if), .go(go),
      .hs_req(hs_req), .rd(rd), .dev_addr(dev_addr), .ptr(ptr), .wdata(wdata),
      .rdata(rdata), .nack_err(nack_err), .busy(busy), .done(done));
   twi_bus_monitor twi_bus_monitor_i (.mclk(mclk), .nrst(nrst),
      .scl_oe_n_s(bus_if.scl_oe_n_s), .sda_oe_n_s(bus_if.sda_oe_n_s),
      .scl(bus_if.scl), .sda(bus_if.sda));
   // ----------------
   // Clock, store, watch
   // ----------------
   always #20 mclk = ~mclk;
   assign rd_data = mem[reg_ptr];
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (!nrst) begin
         for (int j = 0; j < 256; j++) mem[j] <= 8'(j) ^ 8'ha5;
      end
      if (wr_stb) mem[reg_ptr - 8'h01] <= wr_data;
      if (snap_stb) n_snap <= n_snap + 1;
      if (go) begin
         hs_seen <= 1'b0;
         hs_drop <= 1'b0;
      end else begin
         if (hs_mode) hs_seen <= 1'b1;
         if (hs_seen && !hs_mode && !bus_if.scl) hs_drop <= 1'b1;
      end
      if (cyc == 80000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   // ----------------
   // Helpers
   // ----------------
   function automatic logic [7:0] ptr_after(input logic [7:0] p);
      return p + 8'h01;
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic s, input logic [6:0] a, input logic r,
         input logic h, input logic [7:0] p, input logic [7:0] d);
      int k;
      @(posedge mclk);
      #1;
      addr_sel = s;
      dev_addr = a;
      rd = r;
      hs_req = h;
      ptr = p;
      wdata = d;
      go = 1'b1;
      @(posedge mclk);
      #1;
      go = 1'b0;
      for (k = 0; k < 6000 && done !== 1'b1; k++) begin
         @(posedge mclk);
         #1;
      end
      chk({7'h00, done}, 8'h01);
      // Let the slave see the stop and commit
      repeat (8) @(posedge mclk);
      #1;
   endtask
   task automatic tally_and_finish();
      if (n_errors == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ----------------
   // Main sequence
   // ----------------
   initial begin
      int i, rnd, snap0;
      logic s, h;
      logic [7:0] p, d;
      for (i = 0; i < 256; i++) begin
         exp_mem[i] = i[7:0] ^ 8'ha5;
      end
      rnd = $urandom(63);
      repeat (8) @(posedge mclk);
      #1;
      nrst = 1'b1;
      chk({7'h00, hs_mode}, 8'h00);
      for (i = 0; i < 10; i++) begin
         s = 1'($urandom);
         h = (i < 2) ? i[0] : 1'($urandom);
         p = (i == 0) ? 8'hff : 8'($urandom);
         d = 8'($urandom);
         xfer(s, s ? 7'h48 : 7'h40, 1'b0, h, p, d);
         exp_mem[p] = d;
         chk({7'h00, nack_err}, 8'h00);
         chk(mem[p], exp_mem[p]);
         chk(reg_ptr, ptr_after(p));
         chk({7'h00, hs_seen}, {7'h00, h});
         chk({7'h00, hs_mode}, 8'h00);
         snap0 = n_snap;
         xfer(s, s ? 7'h48 : 7'h40, 1'b1, h, p, 8'h00);
         chk(rdata, exp_mem[p]);
         chk(8'(n_snap - snap0), 8'h01);
         chk({7'h00, hs_drop}, 8'h00);
         chk({7'h00, hs_seen}, {7'h00, h});
      end
      for (i = 0; i < 4; i++) begin
         p = reg_ptr;
         xfer(i != 2, bad[i], i[0], 1'b0, 8'h33, 8'hc3);
         chk({7'h00, nack_err}, 8'h01);
         chk(reg_ptr, p);
         chk(mem[8'h33], exp_mem[8'h33]);
      end
      tally_and_finish();
   end
endmodule // i2c_slave_register_port_tb
